/* design/flash_host_regs.svh */
`ifndef FLASH_HOST_REGS_SVH
`define FLASH_HOST_REGS_SVH
`define ADR_UNLOCK1   17'h00555
`define ADR_UNLOCK2   17'h002aa
`define ADR_ANY       17'h00000
`define DAT_UNLOCK1   8'haa
`define DAT_UNLOCK2   8'h55
`define DAT_RESET     8'hf0
`define DAT_AUTOSEL   8'h90
`define DAT_PROGRAM   8'ha0
`define DAT_BYPASS    8'h20
`define DAT_BYP_EXIT  8'h00
`define DAT_ERASE     8'h80
`define DAT_CHIP      8'h10
`define DAT_BLOCK     8'h30
`define DAT_SUSPEND   8'hb0
`define DAT_RESUME    8'h30
`define CYC_NS        4
`define T_WP_NS       45
`define T_WH_NS       30
`define T_ACC_NS      45
`define T_ABORT_US    10
`define T_WIN_US      50
`define WP_CYC        ((`T_WP_NS + `CYC_NS - 1) / `CYC_NS)
`define WH_CYC        ((`T_WH_NS + `CYC_NS - 1) / `CYC_NS)
`define ACC_CYC       (((`T_ACC_NS + `CYC_NS - 1) / `CYC_NS) + 2)
`define ABORT_CYC     ((`T_ABORT_US * 1000 + `CYC_NS - 1) / `CYC_NS)
`define WIN_CYC       ((`T_WIN_US * 1000) / `CYC_NS)
`endif

/* design/flash_host_pkg.sv */
package flash_host_pkg;
    typedef enum logic [3:0] {
        OP_READ       = 4'h0,
        OP_RESET1     = 4'h1,
        OP_RESET3     = 4'h2,
        OP_AUTOSEL    = 4'h3,
        OP_PROG       = 4'h4,
        OP_BYP_ENTER  = 4'h5,
        OP_BYP_PROG   = 4'h6,
        OP_BYP_EXIT   = 4'h7,
        OP_CHIP_ERASE = 4'h8,
        OP_BLK_ERASE  = 4'h9,
        OP_BLK_ADD    = 4'ha,
        OP_SUSPEND    = 4'hb,
        OP_RESUME     = 4'hc
    } op_t;
    typedef enum logic [2:0] {
        S_IDLE  = 3'h0,
        S_SETUP = 3'h1,
        S_PULSE = 3'h2,
        S_HOLD  = 3'h3,
        S_READ  = 3'h4,
        S_ABORT = 3'h5
    } state_t;
endpackage

/* design/flash_host.sv */
`timescale 1ns/100ps
`default_nettype none
`include "flash_host_regs.svh"
module flash_host #(
    parameter int WIN_CYC = `WIN_CYC
) (
    input  wire logic        REF_CLK,
    input  wire logic        RST_B,
    input  wire logic        CLK_EN,
    input  wire logic        CMD_VALID,
    output logic             CMD_READY,
    input  wire logic [3:0]  CMD_OP,
    input  wire logic [16:0] CMD_ADDR,
    input  wire logic [7:0]  CMD_DATA,
    output logic             CMD_REJECT,
    output logic             RSP_VALID,
    output logic [7:0]       RSP_DATA,
    output logic             BYPASS_ACTIVE,
    output logic             BLOCK_WINDOW_OPEN,
    output logic [16:0]      FL_ADDR,
    output logic             FL_CE_B,
    output logic             FL_OE_B,
    output logic             FL_WE_B,
    input  wire logic [7:0]  FL_DQ_I,
    output logic [7:0]       FL_DQ_O,
    output logic             FL_DQ_OE
);
    localparam logic [13:0] WP_N    = 14'(`WP_CYC);
    localparam logic [13:0] WH_N    = 14'(`WH_CYC);
    localparam logic [13:0] ACC_N   = 14'(`ACC_CYC);
    localparam logic [13:0] ABORT_N = 14'(`ABORT_CYC);
    localparam logic [13:0] WIN_N   = 14'(WIN_CYC);

    if (WIN_CYC < 1 || WIN_CYC > 16383) begin : g_chk
        $error("WIN_CYC out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequence table
    function automatic logic [24:0] seq_word(input flash_host_pkg::op_t op,
                                             input logic [2:0] idx,
                                             input logic [16:0] a,
                                             input logic [7:0] d);
        logic [24:0] ul;
        logic [24:0] w;
        ul = (idx == 3'h1 || idx == 3'h4) ? {`ADR_UNLOCK2, `DAT_UNLOCK2}
                                          : {`ADR_UNLOCK1, `DAT_UNLOCK1};
        w  = ul;
        unique case (op)
            flash_host_pkg::OP_READ:      w = {a, 8'h00};
            flash_host_pkg::OP_RESET1:    w = {`ADR_ANY, `DAT_RESET};
            flash_host_pkg::OP_RESET3:
                if (idx == 3'h2) w = {`ADR_ANY, `DAT_RESET};
            flash_host_pkg::OP_AUTOSEL:
                if (idx == 3'h2) w = {`ADR_UNLOCK1, `DAT_AUTOSEL};
            flash_host_pkg::OP_PROG: begin
                if (idx == 3'h2) w = {`ADR_UNLOCK1, `DAT_PROGRAM};
                if (idx == 3'h3) w = {a, d};
            end
            flash_host_pkg::OP_BYP_ENTER:
                if (idx == 3'h2) w = {`ADR_UNLOCK1, `DAT_BYPASS};
            flash_host_pkg::OP_BYP_PROG:
                w = (idx == 3'h0) ? {`ADR_ANY, `DAT_PROGRAM} : {a, d};
            flash_host_pkg::OP_BYP_EXIT:
                w = (idx == 3'h0) ? {`ADR_ANY, `DAT_AUTOSEL}
                                  : {`ADR_ANY, `DAT_BYP_EXIT};
            flash_host_pkg::OP_CHIP_ERASE, flash_host_pkg::OP_BLK_ERASE: begin
                if (idx == 3'h2) w = {`ADR_UNLOCK1, `DAT_ERASE};
                if (idx == 3'h5) w = (op == flash_host_pkg::OP_CHIP_ERASE)
                                     ? {`ADR_UNLOCK1, `DAT_CHIP}
                                     : {a, `DAT_BLOCK};
            end
            flash_host_pkg::OP_BLK_ADD:   w = {a, `DAT_BLOCK};
            flash_host_pkg::OP_SUSPEND:   w = {`ADR_ANY, `DAT_SUSPEND};
            flash_host_pkg::OP_RESUME:    w = {`ADR_ANY, `DAT_RESUME};
            default:                      w = ul;
        endcase
        return w;
    endfunction

    function automatic logic [2:0] seq_last(input flash_host_pkg::op_t op);
        unique case (op)
            flash_host_pkg::OP_RESET3, flash_host_pkg::OP_AUTOSEL,
            flash_host_pkg::OP_BYP_ENTER:                          return 3'h2;
            flash_host_pkg::OP_PROG:                               return 3'h3;
            flash_host_pkg::OP_BYP_PROG, flash_host_pkg::OP_BYP_EXIT: return 3'h1;
            flash_host_pkg::OP_CHIP_ERASE, flash_host_pkg::OP_BLK_ERASE: return 3'h5;
            default:                                               return 3'h0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchroniser
    logic [7:0] dq_s1_q;
    logic [7:0] dq_s2_q;
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            dq_s1_q <= 8'h00;
            dq_s2_q <= 8'h00;
        end else if (CLK_EN) begin
            dq_s1_q <= FL_DQ_I;
            dq_s2_q <= dq_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    flash_host_pkg::state_t st_q, st_d;
    flash_host_pkg::op_t    op_q, op_d, op_in;
    logic [2:0]  idx_q, idx_d;
    logic [13:0] cnt_q, cnt_d;
    logic [13:0] win_q, win_d;
    logic [16:0] a_q, a_d;
    logic [7:0]  d_q, d_d;
    logic        byp_q, byp_d;
    logic        rej_q, rej_d;
    logic        rv_q, rv_d;
    logic [7:0]  rd_q, rd_d;
    logic [16:0] pa_q, pa_d;
    logic [7:0]  po_q, po_d;
    logic        ce_q, ce_d, oe_q, oe_d, we_q, we_d, doe_q, doe_d;
    logic        byp_ok;
    logic        refuse;
    logic [24:0] word;

    assign op_in = flash_host_pkg::op_t'(CMD_OP);

    always_comb begin
        st_d  = st_q;
        op_d  = op_q;
        idx_d = idx_q;
        cnt_d = cnt_q;
        a_d   = a_q;
        d_d   = d_q;
        byp_d = byp_q;
        rej_d = 1'b0;
        rv_d  = 1'b0;
        rd_d  = rd_q;
        win_d = (win_q != 14'h0) ? win_q - 14'h1 : win_q;
        // While in bypass only reads, the single-write reset, bypass program and exit go out
        byp_ok = (op_in == flash_host_pkg::OP_READ) || (op_in == flash_host_pkg::OP_RESET1)
              || (op_in == flash_host_pkg::OP_BYP_PROG) || (op_in == flash_host_pkg::OP_BYP_EXIT);
        refuse = (byp_q != byp_ok && op_in != flash_host_pkg::OP_READ
                  && op_in != flash_host_pkg::OP_RESET1)
              || (op_in == flash_host_pkg::OP_BLK_ADD && win_q == 14'h0)
              || (CMD_OP > 4'hc);
        unique case (st_q)
            flash_host_pkg::S_IDLE:
                if (CMD_VALID) begin
                    if (refuse) begin
                        rej_d = 1'b1;
                    end else begin
                        op_d  = op_in;
                        a_d   = CMD_ADDR;
                        d_d   = CMD_DATA;
                        idx_d = 3'h0;
                        cnt_d = 14'h0;
                        st_d  = (op_in == flash_host_pkg::OP_READ) ? flash_host_pkg::S_READ
                                                                   : flash_host_pkg::S_SETUP;
                    end
                end
            flash_host_pkg::S_SETUP: begin
                // Address is stable a cycle before the enable falls
                st_d  = flash_host_pkg::S_PULSE;
                cnt_d = WP_N - 14'h1;
            end
            flash_host_pkg::S_PULSE:
                if (cnt_q == 14'h0) begin
                    st_d  = flash_host_pkg::S_HOLD;
                    cnt_d = WH_N - 14'h1;
                end else begin
                    cnt_d = cnt_q - 14'h1;
                end
            flash_host_pkg::S_HOLD:
                if (cnt_q != 14'h0) begin
                    cnt_d = cnt_q - 14'h1;
                end else if (idx_q != seq_last(op_q)) begin
                    idx_d = idx_q + 3'h1;
                    st_d  = flash_host_pkg::S_SETUP;
                end else begin
                    st_d = flash_host_pkg::S_IDLE;
                    if (op_q == flash_host_pkg::OP_BYP_ENTER) byp_d = 1'b1;
                    if (op_q == flash_host_pkg::OP_BYP_EXIT)  byp_d = 1'b0;
                    if (op_q == flash_host_pkg::OP_BLK_ERASE
                        || op_q == flash_host_pkg::OP_BLK_ADD) win_d = WIN_N;
                    if (op_q == flash_host_pkg::OP_SUSPEND
                        || op_q == flash_host_pkg::OP_RESUME) win_d = 14'h0;
                    if (op_q == flash_host_pkg::OP_RESET1
                        || op_q == flash_host_pkg::OP_RESET3) begin
                        // Conservative: an abort may be under way, so always wait
                        st_d  = flash_host_pkg::S_ABORT;
                        cnt_d = ABORT_N - 14'h1;
                        win_d = 14'h0;
                    end
                end
            flash_host_pkg::S_READ:
                if (cnt_q == ACC_N - 14'h1) begin
                    rv_d = 1'b1;
                    rd_d = dq_s2_q;
                    st_d = flash_host_pkg::S_IDLE;
                end else begin
                    cnt_d = cnt_q + 14'h1;
                end
            flash_host_pkg::S_ABORT:
                if (cnt_q == 14'h0) st_d = flash_host_pkg::S_IDLE;
                else cnt_d = cnt_q - 14'h1;
            default: st_d = flash_host_pkg::S_IDLE;
        endcase
        word  = seq_word(op_d, idx_d, a_d, d_d);
        pa_d  = word[24:8];
        po_d  = word[7:0];
        ce_d  = (st_d == flash_host_pkg::S_IDLE) || (st_d == flash_host_pkg::S_ABORT);
        oe_d  = st_d != flash_host_pkg::S_READ;
        we_d  = st_d != flash_host_pkg::S_PULSE;
        doe_d = (st_d == flash_host_pkg::S_SETUP) || (st_d == flash_host_pkg::S_PULSE)
             || (st_d == flash_host_pkg::S_HOLD);
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            st_q  <= flash_host_pkg::S_IDLE;
            op_q  <= flash_host_pkg::OP_READ;
            idx_q <= 3'h0;
            cnt_q <= 14'h0;
            win_q <= 14'h0;
            a_q   <= 17'h00000;
            d_q   <= 8'h00;
            byp_q <= 1'b0;
            rej_q <= 1'b0;
            rv_q  <= 1'b0;
            rd_q  <= 8'h00;
            pa_q  <= 17'h00000;
            po_q  <= 8'h00;
            ce_q  <= 1'b1;
            oe_q  <= 1'b1;
            we_q  <= 1'b1;
            doe_q <= 1'b0;
        end else if (CLK_EN) begin
            st_q  <= st_d;
            op_q  <= op_d;
            idx_q <= idx_d;
            cnt_q <= cnt_d;
            win_q <= win_d;
            a_q   <= a_d;
            d_q   <= d_d;
            byp_q <= byp_d;
            rej_q <= rej_d;
            rv_q  <= rv_d;
            rd_q  <= rd_d;
            pa_q  <= pa_d;
            po_q  <= po_d;
            ce_q  <= ce_d;
            oe_q  <= oe_d;
            we_q  <= we_d;
            doe_q <= doe_d;
        end
    end

    assign CMD_READY         = st_q == flash_host_pkg::S_IDLE;
    assign CMD_REJECT        = rej_q;
    assign RSP_VALID         = rv_q;
    assign RSP_DATA          = rd_q;
    assign BYPASS_ACTIVE     = byp_q;
    assign BLOCK_WINDOW_OPEN = win_q != 14'h0;
    assign FL_ADDR           = pa_q;
    assign FL_CE_B           = ce_q;
    assign FL_OE_B           = oe_q;
    assign FL_WE_B           = we_q;
    assign FL_DQ_O           = po_q;
    assign FL_DQ_OE          = doe_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);
    logic we_prev_q;
    logic wfall;
    // Write-enable history kept in a flop, not a sampled-value call
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            we_prev_q <= 1'b1;
        end else if (CLK_EN) begin
            we_prev_q <= FL_WE_B;
        end
    end
    assign wfall = !FL_WE_B && we_prev_q;

    a_reset_code: assert property (wfall && op_q inside {flash_host_pkg::OP_RESET1,
        flash_host_pkg::OP_RESET3} && idx_q == seq_last(op_q) |-> FL_DQ_O == 8'hf0)
        else $error("reset write lacks f0");
    a_abort_wait: assert property ($rose(st_q == flash_host_pkg::S_ABORT)
        |-> !CMD_READY [*8])
        else $error("abort wait cut short");
    a_unlock_first: assert property (wfall && idx_q == 3'h0 && op_q inside
        {flash_host_pkg::OP_AUTOSEL, flash_host_pkg::OP_PROG, flash_host_pkg::OP_RESET3}
        |-> FL_ADDR == 17'h00555 && FL_DQ_O == 8'haa && !FL_CE_B && FL_DQ_OE)
        else $error("bad first unlock write");
    a_prog_target: assert property (wfall && op_q == flash_host_pkg::OP_PROG
        && idx_q == 3'h3 |-> FL_ADDR == a_q && FL_DQ_O == d_q)
        else $error("program target mismatch");
    a_bypass_gate: assert property (CMD_VALID && CMD_READY && byp_q &&
        op_in inside {flash_host_pkg::OP_PROG, flash_host_pkg::OP_CHIP_ERASE,
                      flash_host_pkg::OP_AUTOSEL}
        |=> CMD_REJECT && st_q == flash_host_pkg::S_IDLE)
        else $error("non bypass op sent in bypass");
    a_bypass_prog: assert property (wfall && op_q == flash_host_pkg::OP_BYP_PROG
        |-> FL_DQ_O == (idx_q == 3'h0 ? 8'ha0 : d_q))
        else $error("bypass program write wrong");
    a_bypass_exit: assert property (wfall && op_q == flash_host_pkg::OP_BYP_EXIT
        && idx_q == 3'h1 |-> FL_DQ_O == 8'h00 ##[1:40] !BYPASS_ACTIVE)
        else $error("bypass exit failed");
    a_chip_last: assert property (wfall && op_q == flash_host_pkg::OP_CHIP_ERASE
        && idx_q == 3'h5 |-> FL_ADDR == 17'h00555 && FL_DQ_O == 8'h10)
        else $error("chip erase final write wrong");
    a_block_window: assert property (CMD_VALID && CMD_READY && win_q == 14'h0
        && op_in == flash_host_pkg::OP_BLK_ADD |=> CMD_REJECT)
        else $error("block add outside window");
    a_suspend_code: assert property (wfall && op_q == flash_host_pkg::OP_SUSPEND
        |-> FL_DQ_O == 8'hb0 && FL_DQ_OE)
        else $error("suspend code wrong");
endmodule
`default_nettype wire

/* sim/flash_dev_model.sv */
`timescale 1ns/100ps
`default_nettype none
module flash_dev_model #(
    parameter logic [7:0] MAKER_ID = 8'h5c, // Arbitrary value
    parameter logic [7:0] PART_ID  = 8'hc5, // Arbitrary value
    parameter logic [7:0] PROT     = 8'h80,
    parameter int         PROG_NS  = 400,
    parameter int         ABORT_NS = 10000
) (
    input  wire logic        CE_B,
    input  wire logic        OE_B,
    input  wire logic        WE_B,
    input  wire logic [16:0] ADDR,
    input  wire logic [7:0]  DIN,
    output logic [7:0]       DOUT
);
    logic [7:0]  mem [0:131071];
    logic [7:0]  last, stat, v;
    logic [2:0]  cyc, eb;
    logic        busy, idm, byp, abt;
    logic [16:0] al;
    logic [10:0] ca;
    wire         rd = !CE_B && !OE_B && WE_B;
    initial begin
        foreach (mem[i]) mem[i] = 8'hff;
        {cyc, eb, busy, idm, byp, abt, last, stat, al} = '0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic prog(input logic [16:0] a, input logic [7:0] d);
        if (PROT[a[16:14]]) return;
        busy = 1'b1;
        stat = {~d[7], 7'h00};
        #(PROG_NS);
        mem[a] = mem[a] & d;
        busy = 1'b0;
    endtask
    // Erase is instant; only the decode path matters to the host
    task automatic erase(input logic all, input logic [2:0] b);
        for (int i = 0; i < 131072; i++)
            if (!PROT[i[16:14]] && (all || i[16:14] == b)) mem[i] = 8'hff;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(negedge WE_B or negedge CE_B) begin
        if (!CE_B && !WE_B) al = ADDR;
    end
    always @(posedge WE_B or posedge CE_B) begin
        if (WE_B != CE_B && OE_B && !busy) begin
            ca = al[10:0];
            if (DIN == 8'hf0 && (cyc == 3'd0 || cyc == 3'd2 || cyc == 3'd6)) begin
                if (cyc == 3'd6) begin
                    abt = 1'b1;
                    for (int i = 0; i < 16384; i++) mem[{eb, i[13:0]}] = 8'hxx;
                    #(ABORT_NS);
                    abt = 1'b0;
                end
                cyc = 3'd0;
                idm = 1'b0;
            end else if (byp) begin
                if (cyc == 3'd0 && DIN == 8'ha0) cyc = 3'd1;
                else if (cyc == 3'd0 && DIN == 8'h90) cyc = 3'd7;
                else if (cyc == 3'd1) begin
                    cyc = 3'd0;
                    prog(al, DIN);
                end else begin
                    if (cyc == 3'd7 && DIN == 8'h00) byp = 1'b0;
                    cyc = 3'd0;
                end
            end else begin
                idm = 1'b0;
                case (cyc)
                    3'd0, 3'd4: cyc = (ca == 11'h555 && DIN == 8'haa) ? cyc + 3'd1 : 3'd0;
                    3'd1, 3'd5: cyc = (ca == 11'h2aa && DIN == 8'h55) ? cyc + 3'd1 : 3'd0;
                    3'd2: begin
                        cyc = 3'd0;
                        if (ca == 11'h555) begin
                            case (DIN)
                                8'h90: idm = 1'b1;
                                8'ha0: cyc = 3'd3;
                                8'h20: byp = 1'b1;
                                8'h80: cyc = 3'd4;
                                default: cyc = 3'd0;
                            endcase
                        end
                    end
                    3'd3: begin
                        cyc = 3'd0;
                        prog(al, DIN);
                    end
                    3'd6: begin
                        cyc = 3'd0;
                        if (DIN == 8'h10 && ca == 11'h555) erase(1'b1, 3'd0);
                        else if (DIN == 8'h30) begin
                            erase(1'b0, al[16:14]);
                            eb = al[16:14];
                            cyc = 3'd6;
                        end
                    end
                    default: cyc = 3'd0;
                endcase
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Released lines show the inverse of the last byte, never a stale match
    always @* begin
        if (abt) v = 8'hxx;
        else if (busy) v = stat;
        else if (idm) v = ADDR[1] ? {7'h00, PROT[ADDR[16:14]]} : (ADDR[0] ? PART_ID : MAKER_ID);
        else v = mem[ADDR];
        if (rd) begin
            DOUT = v;
            last = v;
        end else DOUT = ~last;
    end
endmodule
`default_nettype wire

/* sim/flash_host_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module flash_host_tb;
    logic        ref_clk = 1'b0, rst_b = 1'b0, cmd_valid = 1'b0;
    logic [3:0]  cmd_op = 4'h0;
    logic [16:0] cmd_addr = 17'h00000;
    logic [7:0]  cmd_data = 8'h00;
    logic        rdy, rej, rsp_v, byp, win, ce_b, oe_b, we_b, dq_oe;
    logic [7:0]  rsp_d, dq_o, dev_q;
    logic [16:0] fl_a;
    int          err_count = 0, n_compared = 0;
    wire  [7:0]  dq_i = dq_oe ? dq_o : dev_q;
    always #2 ref_clk = ~ref_clk;
    flash_host #(.WIN_CYC(40)) flash_host_i (
        .REF_CLK(ref_clk), .RST_B(rst_b), .CLK_EN(1'b1), .CMD_VALID(cmd_valid),
        .CMD_READY(rdy), .CMD_OP(cmd_op), .CMD_ADDR(cmd_addr), .CMD_DATA(cmd_data),
        .CMD_REJECT(rej), .RSP_VALID(rsp_v), .RSP_DATA(rsp_d), .BYPASS_ACTIVE(byp),
        .BLOCK_WINDOW_OPEN(win), .FL_ADDR(fl_a), .FL_CE_B(ce_b), .FL_OE_B(oe_b),
        .FL_WE_B(we_b), .FL_DQ_I(dq_i), .FL_DQ_O(dq_o), .FL_DQ_OE(dq_oe));
    flash_dev_model flash_dev_model_i (
        .CE_B(ce_b), .OE_B(oe_b), .WE_B(we_b), .ADDR(fl_a), .DIN(dq_o), .DOUT(dev_q));
    ////////////////////////////////////////////////////////////////////////////////
    // Sample on the falling edge so registered outputs have settled
    task automatic cmd(input logic [3:0] op, input logic [16:0] a, input logic [7:0] d,
                       output logic [7:0] q, output logic r);
        int n;
        q = 8'hxx;
        r = 1'b0;
        cmd_op <= op;
        cmd_addr <= a;
        cmd_data <= d;
        cmd_valid <= 1'b1;
        for (n = 0; n < 9000 && rdy !== 1'b1; n++) @(negedge ref_clk);
        if (n == 9000) begin
            err_count++;
            test_done();
        end
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        for (n = 0; n < 12000; n++) begin
            @(negedge ref_clk);
            if (rsp_v === 1'b1) q = rsp_d;
            if (rej === 1'b1) r = 1'b1;
            if (n >= 2 && rdy === 1'b1) break;
        end
        if (n == 12000) begin
            err_count++;
            test_done();
        end
        @(posedge ref_clk);
    endtask
    // Polls through the status phase; bounded so a stuck part still ends
    task automatic rd_until(input logic [16:0] a, input logic [7:0] e);
        logic [7:0] q;
        logic       r;
        for (int i = 0; i < 8; i++) begin
            cmd(4'h0, a, 8'h00, q, r);
            if (q === e) break;
        end
        `CHK(q, e)
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_program;
        logic [7:0] q;
        logic       r;
        cmd(4'h4, 17'h01234, 8'h5a, q, r);
        cmd(4'h0, 17'h01234, 8'h00, q, r);
        `CHK(q, 8'h80)
        rd_until(17'h01234, 8'h5a);
        cmd(4'h4, 17'h01234, 8'h0f, q, r);
        rd_until(17'h01234, 8'h0a);
        cmd(4'h4, 17'h1c010, 8'h00, q, r);
        cmd(4'h0, 17'h1c010, 8'h00, q, r);
        `CHK(q, 8'hff)
        cmd(4'h4, 17'h18010, 8'h00, q, r);
        rd_until(17'h18010, 8'h00);
        $display("program test done");
    endtask
    task automatic t_autosel;
        logic [7:0] q;
        logic       r;
        cmd(4'h3, 17'h00000, 8'h00, q, r);
        cmd(4'h0, 17'h00000, 8'h00, q, r);
        `CHK(q, 8'h5c)
        cmd(4'h0, 17'h0fd01, 8'h00, q, r);
        `CHK(q, 8'hc5)
        cmd(4'h0, 17'h1c002, 8'h00, q, r);
        `CHK(q, 8'h01)
        cmd(4'h0, 17'h18002, 8'h00, q, r);
        `CHK(q, 8'h00)
        cmd(4'h2, 17'h00000, 8'h00, q, r);
        cmd(4'h0, 17'h01234, 8'h00, q, r);
        `CHK(q, 8'h0a)
        $display("auto select test done");
    endtask
    task automatic t_bypass;
        logic [7:0] q;
        logic       r;
        cmd(4'h5, 17'h00000, 8'h00, q, r);
        `CHK(byp, 1'b1)
        cmd(4'h6, 17'h02000, 8'h33, q, r);
        rd_until(17'h02000, 8'h33);
        cmd(4'h3, 17'h00000, 8'h00, q, r);
        `CHK(r, 1'b1)
        cmd(4'h1, 17'h00000, 8'h00, q, r);
        `CHK(byp, 1'b1)
        cmd(4'h6, 17'h02001, 8'h44, q, r);
        rd_until(17'h02001, 8'h44);
        cmd(4'h7, 17'h00000, 8'h00, q, r);
        `CHK(byp, 1'b0)
        cmd(4'h6, 17'h02002, 8'h00, q, r);
        `CHK(r, 1'b1)
        cmd(4'hd, 17'h00000, 8'h00, q, r);
        `CHK(r, 1'b1)
        $display("bypass test done");
    endtask
    task automatic t_erase;
        logic [7:0] q;
        logic       r;
        cmd(4'h9, 17'h01000, 8'h00, q, r);
        `CHK(win, 1'b1)
        cmd(4'ha, 17'h08000, 8'h00, q, r);
        `CHK(r, 1'b0)
        cmd(4'hb, 17'h00000, 8'h00, q, r);
        `CHK(win, 1'b0)
        cmd(4'ha, 17'h08000, 8'h00, q, r);
        `CHK(r, 1'b1)
        rd_until(17'h01234, 8'hff);
        cmd(4'hc, 17'h00000, 8'h00, q, r);
        cmd(4'h8, 17'h00000, 8'h00, q, r);
        rd_until(17'h18010, 8'hff);
        cmd(4'h9, 17'h04000, 8'h00, q, r);
        cmd(4'h1, 17'h00000, 8'h00, q, r);
        cmd(4'h0, 17'h01234, 8'h00, q, r);
        `CHK(q, 8'hff)
        $display("erase test done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge ref_clk);
        err_count++;
        test_done();
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        t_program();
        t_autosel();
        t_bypass();
        t_erase();
        test_done();
    end
endmodule
`default_nettype wire
